/* File: core/sdcd_device.sv */
// device end: command decode, bank state and clock-gate mode handling
`timescale 1ns/100ps
module sdcd_device
    import sdcd_pkg::*;
#(
    parameter logic [3:0] BURST_LEN = BURST_LEN_DEF
)(
    // clock and reset
    input  wire logic                clock,
    input  wire logic                nrst,
    // pins
    sdcd_if.dev                      pins,
    // user side
    output sdcd_cmd_type             cmd_q,
    output logic                     cmd_valid_q,
    output logic [BANK_W-1:0]        cmd_bank_q,
    output logic [ADDR_W-1:0]        cmd_addr_q,
    output logic                     illegal_q,
    output logic [NUM_BANKS-1:0]     bank_open_q,
    output logic                     burst_busy,
    output sdcd_mode_type            mode_q,
    output logic [MASK_W-1:0]        write_en_q,
    output logic                     out_drive_q,
    input  wire logic                full_page
);
    import sdcd_pkg::*;

    // pins come from another chip: two-stage synchronisers
    localparam int SYNC_W = 5 + MASK_W + BANK_W + ADDR_W;
    // reset to idle pin levels: all zeros would look like a gate drop on the first edges
    localparam logic [SYNC_W-1:0] SYNC_IDLE = {5'h1F, {MASK_W{1'b1}}, {(BANK_W+ADDR_W){1'b0}}};
    logic [SYNC_W-1:0] sync1_q, sync2_q;
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            sync1_q <= SYNC_IDLE;
            sync2_q <= SYNC_IDLE;
        end
        else
        begin
            sync1_q <= {pins.clock_gate_now, pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n,
                        pins.byte_mask, pins.bank_sel_hi, pins.bank_sel_lo, pins.addr};
            sync2_q <= sync1_q;
        end
    end

    logic                gate_now, cs_n, ras_n, cas_n, we_n;
    logic [MASK_W-1:0]   mask;
    logic [BANK_W-1:0]   bank;
    logic [ADDR_W-1:0]   addr;
    assign {gate_now, cs_n, ras_n, cas_n, we_n, mask, bank, addr} = sync2_q;

    logic clock_gate_prev_q;
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            clock_gate_prev_q <= 1'b1;
        else
            clock_gate_prev_q <= gate_now;
    end

    logic [3:0] burst_cnt_q;
    logic       any_open;
    assign burst_busy = (burst_cnt_q != 4'h0);
    assign any_open   = |bank_open_q;

    // decode of one sampled cycle
    function automatic sdcd_cmd_type decode(input logic cs, input logic [2:0] pat,
                                            input logic pch);
        sdcd_cmd_type c;
        c = SDCD_C_NONE;
        if (cs)
            c = SDCD_C_DESEL;
        else
        begin
            case (pat)
                PAT_NOP: c = SDCD_C_NOP;
                PAT_ACT: c = SDCD_C_ACT;
                PAT_PRE: c = pch ? SDCD_C_PREALL : SDCD_C_PRE;
                PAT_WR:  c = pch ? SDCD_C_WRA : SDCD_C_WR;
                PAT_RD:  c = pch ? SDCD_C_RDA : SDCD_C_RD;
                PAT_MRS: c = SDCD_C_MRS;
                PAT_REF: c = SDCD_C_REF;
                PAT_BST: c = SDCD_C_BST;
                default: c = SDCD_C_NONE;
            endcase
        end
        return c;
    endfunction

    sdcd_cmd_type raw;
    logic         sref_entry, pd_entry, gate_exit, take;
    assign raw = decode(cs_n, {ras_n, cas_n, we_n}, addr[PCH_BIT]);
    // entry and exit decided by previous versus current gate
    assign sref_entry = clock_gate_prev_q && !gate_now && (raw == SDCD_C_REF);
    // self refresh wins by priority; with a bank open it falls back to suspend
    assign pd_entry   = clock_gate_prev_q && !gate_now;
    assign gate_exit  = !clock_gate_prev_q && gate_now;
    // commands only while both samples high and mode normal
    assign take = clock_gate_prev_q && gate_now && (mode_q == SDCD_M_NORMAL);

    // mode: entry registered this edge, effect next edge
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            mode_q <= SDCD_M_NORMAL;
        else
        begin
            case (mode_q)
                SDCD_M_NORMAL:
                    if (sref_entry && !any_open)
                        mode_q <= SDCD_M_SREF;
                    else if (pd_entry && (any_open || burst_busy))
                        mode_q <= SDCD_M_SUSPEND;
                    else if (pd_entry)
                        mode_q <= SDCD_M_PDOWN;
                SDCD_M_SUSPEND, SDCD_M_PDOWN, SDCD_M_SREF:
                    if (gate_exit)
                        mode_q <= SDCD_M_NORMAL;
                default: mode_q <= SDCD_M_NORMAL;
            endcase
        end
    end

    // legality against bank state
    logic legal;
    always_comb
    begin
        legal = 1'b1;
        case (raw)
            SDCD_C_ACT:                       legal = !bank_open_q[bank];
            SDCD_C_RD, SDCD_C_RDA,
            SDCD_C_WR, SDCD_C_WRA:            legal = bank_open_q[bank];
            SDCD_C_MRS, SDCD_C_REF:           legal = !any_open;
            SDCD_C_BST:                       legal = burst_busy && full_page;
            default:                          legal = 1'b1;
        endcase
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            cmd_q       <= SDCD_C_NONE;
            cmd_valid_q <= 1'b0;
            cmd_bank_q  <= '0;
            cmd_addr_q  <= '0;
            illegal_q   <= 1'b0;
        end
        else
        begin
            cmd_valid_q <= take;
            cmd_q       <= take ? raw : SDCD_C_NONE;
            illegal_q   <= take && !legal;
            if (take)
            begin
                cmd_bank_q <= bank;
                cmd_addr_q <= addr;
            end
        end
    end

    // pending auto-precharge: bank to close when a fixed-length burst ends; a full-page burst leaves it pending
    logic              apch_q;
    logic [BANK_W-1:0] apch_bank_q;
    logic              burst_last;
    assign burst_last = (mode_q == SDCD_M_NORMAL) && (burst_cnt_q == 4'h1) && !full_page;

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            apch_q      <= 1'b0;
            apch_bank_q <= '0;
        end
        else if (take && legal && (raw inside {SDCD_C_RDA, SDCD_C_WRA}))
        begin
            apch_q      <= 1'b1;
            apch_bank_q <= bank;
        end
        else if (burst_last)
            apch_q <= 1'b0;
    end

    // bank state: illegal commands do not alter it
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            bank_open_q <= '0;
        else
        begin
            if (take && legal)
            begin
                case (raw)
                    SDCD_C_ACT:    bank_open_q[bank] <= 1'b1;
                    SDCD_C_PRE:    bank_open_q[bank] <= 1'b0;
                    SDCD_C_PREALL: bank_open_q <= '0;
                    default:       bank_open_q <= bank_open_q;
                endcase
            end
            // auto-precharge closes its bank as the burst runs out
            if (apch_q && burst_last)
                bank_open_q[apch_bank_q] <= 1'b0;
        end
    end

    // burst counter: frozen in suspend, untouched by no-op or deselect
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            burst_cnt_q <= 4'h0;
        else if (mode_q == SDCD_M_NORMAL)
        begin
            if (take && legal && (raw inside {SDCD_C_RD, SDCD_C_RDA, SDCD_C_WR, SDCD_C_WRA}))
                burst_cnt_q <= full_page ? FULL_PAGE_LEN : BURST_LEN;
            else if (take && legal && (raw == SDCD_C_BST))
                burst_cnt_q <= 4'h0;
            else if (burst_busy && !full_page)
                burst_cnt_q <= burst_cnt_q - 4'h1;
        end
    end

    // byte mask: low enables, high masks; drive needs a taken command, an open bank and a mask that is not all high
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            write_en_q  <= '0;
            out_drive_q <= 1'b0;
        end
        else
        begin
            write_en_q  <= (any_open && take) ? ~mask : '0;
            out_drive_q <= any_open && take && !(&mask);
        end
    end
endmodule

/* File: core/sdcd_pkg.sv */
// package: command codes, device states and pin widths for the sdram command decoder
package sdcd_pkg;
    localparam int BANK_W     = 2;
    localparam int ADDR_W     = 12;
    localparam int NUM_BANKS  = 4;
    localparam int PCH_BIT    = 10;
    localparam int MASK_W     = 2;
    // strobe pattern {row, col, write}, active low
    localparam logic [2:0] PAT_ACT   = 3'h3;
    localparam logic [2:0] PAT_PRE   = 3'h2;
    localparam logic [2:0] PAT_WR    = 3'h4;
    localparam logic [2:0] PAT_RD    = 3'h5;
    localparam logic [2:0] PAT_MRS   = 3'h0;
    localparam logic [2:0] PAT_REF   = 3'h1;
    localparam logic [2:0] PAT_BST   = 3'h6;
    localparam logic [2:0] PAT_NOP   = 3'h7;
    localparam logic [3:0] BURST_LEN_DEF = 4'h4;
    localparam logic [3:0] FULL_PAGE_LEN = 4'hF;

    typedef enum logic [3:0] {
        SDCD_C_NONE, SDCD_C_DESEL, SDCD_C_NOP, SDCD_C_ACT, SDCD_C_PRE, SDCD_C_PREALL,
        SDCD_C_WR, SDCD_C_WRA, SDCD_C_RD, SDCD_C_RDA, SDCD_C_MRS, SDCD_C_REF,
        SDCD_C_BST, SDCD_C_SREF
    } sdcd_cmd_type;

    typedef enum logic [2:0] {
        SDCD_M_NORMAL, SDCD_M_SUSPEND, SDCD_M_PDOWN, SDCD_M_SREF
    } sdcd_mode_type;
endpackage

/* File: core/sdcd_if.sv */
// interface: sdram command pins between controller and device
`timescale 1ns/100ps
interface sdcd_if;
    import sdcd_pkg::*;
    logic                clock_gate_now;
    logic                cs_n;
    logic                ras_n;
    logic                cas_n;
    logic                we_n;
    logic [MASK_W-1:0]   byte_mask;
    logic                bank_sel_lo;
    logic                bank_sel_hi;
    logic [ADDR_W-1:0]   addr;

    modport ctrl (output clock_gate_now, cs_n, ras_n, cas_n, we_n, byte_mask,
                  bank_sel_lo, bank_sel_hi, addr);
    modport dev  (input  clock_gate_now, cs_n, ras_n, cas_n, we_n, byte_mask,
                  bank_sel_lo, bank_sel_hi, addr);
endinterface

/* File: core/sdcd_ctrl.sv */
// controller end: drives command pins from user requests, idles with no-op
`timescale 1ns/100ps
module sdcd_ctrl
    import sdcd_pkg::*;
(
    // clock and reset
    input  wire logic                clock,
    input  wire logic                nrst,
    // user request
    input  wire logic                req_valid,
    input  wire logic [2:0]          req_pattern,
    input  wire logic [BANK_W-1:0]   req_bank,
    input  wire logic [ADDR_W-1:0]   req_addr,
    input  wire logic [MASK_W-1:0]   req_mask,
    input  wire logic                gate_req,
    output logic                     req_ready,
    // pins
    sdcd_if.ctrl                     pins
);
    import sdcd_pkg::*;

    logic gate_q, exit_nop_q;
    logic [2:0] pat_q;
    logic cs_q;
    logic [BANK_W-1:0] bank_q;
    logic [ADDR_W-1:0] addr_q;
    logic [MASK_W-1:0] mask_q;

    // after raising the gate, a no-op must follow
    // a refresh may ride on the gate drop: that is the only way into self refresh
    assign req_ready = gate_q && !exit_nop_q && (gate_req || (req_pattern == PAT_REF));

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            gate_q     <= 1'b1;
            exit_nop_q <= 1'b0;
        end
        else
        begin
            gate_q     <= gate_req;
            exit_nop_q <= gate_req && !gate_q;
        end
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            cs_q   <= 1'b0;
            pat_q  <= PAT_NOP;
            bank_q <= '0;
            addr_q <= '0;
            mask_q <= '1;
        end
        else if (req_valid && req_ready)
        begin
            cs_q   <= 1'b0;
            pat_q  <= req_pattern;
            bank_q <= req_bank;
            addr_q <= req_addr;
            mask_q <= req_mask;
        end
        else
        begin
            cs_q   <= 1'b0;
            pat_q  <= PAT_NOP;
            mask_q <= '1;
        end
    end

    assign pins.clock_gate_now = gate_q;
    assign pins.cs_n           = cs_q;
    assign {pins.ras_n, pins.cas_n, pins.we_n} = pat_q;
    assign pins.byte_mask      = mask_q;
    assign pins.bank_sel_lo    = bank_q[0];
    assign pins.bank_sel_hi    = bank_q[1];
    assign pins.addr           = addr_q;
endmodule

/* File: tb/sdcd_monitor.sv */
// checker: command decode and clock-gate mode assertions
`timescale 1ns/100ps
module sdcd_monitor
    import sdcd_pkg::*;
(
    // clock and reset
    input wire logic             clock,
    input wire logic             nrst,
    // pins
    input wire logic             clock_gate_now,
    input wire logic             cs_n,
    input wire logic             ras_n,
    input wire logic             cas_n,
    input wire logic             we_n,
    input wire logic [ADDR_W-1:0] addr,
    // device results
    input wire sdcd_cmd_type     cmd_q,
    input wire logic             cmd_valid_q,
    input wire logic [NUM_BANKS-1:0] bank_open_q,
    input wire sdcd_mode_type    mode_q
);
    logic [2:0] pat;
    logic       pch;
    assign pat = {ras_n, cas_n, we_n};
    assign pch = addr[PCH_BIT];
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    // gate must be steady long enough to flush the two sync stages
    sequence gate_on;
        clock_gate_now [*5];
    endsequence
    sequence gate_drop;
        clock_gate_now ##1 !clock_gate_now [*4];
    endsequence
    sequence pd_drop;
        clock_gate_now ##1 (!clock_gate_now && !(!cs_n && pat == PAT_REF))
        ##1 !clock_gate_now [*3];
    endsequence
    sequence sref_drop;
        clock_gate_now ##1 (!clock_gate_now && !cs_n && pat == PAT_REF)
        ##1 !clock_gate_now [*3];
    endsequence
    a_nop_decode: assert property (
        gate_on ##0 (!cs_n && pat == PAT_NOP && mode_q == SDCD_M_NORMAL)
        |-> ##3 (cmd_valid_q && cmd_q == SDCD_C_NOP)) else $error("nop lost");
    a_act_source: assert property (
        cmd_valid_q && cmd_q == SDCD_C_ACT |-> $past(pat, 3) == PAT_ACT && !$past(cs_n, 3))
        else $error("act without pattern");
    a_auto_bit: assert property (
        cmd_valid_q && cmd_q inside {SDCD_C_RD, SDCD_C_WR} |-> !$past(pch, 3))
        else $error("auto bit ignored");
    a_prech_all: assert property (
        cmd_valid_q && cmd_q == SDCD_C_PREALL |-> bank_open_q == 0) else $error("bank left open");
    a_suspend_entry: assert property (
        (|bank_open_q && mode_q == SDCD_M_NORMAL) ##0 gate_drop
        |-> ##[0:1] mode_q == SDCD_M_SUSPEND) else $error("no suspend");
    a_suspend_quiet: assert property (
        mode_q == SDCD_M_SUSPEND && $past(mode_q) == SDCD_M_SUSPEND |-> !cmd_valid_q)
        else $error("command in suspend");
    a_suspend_exit: assert property (
        (mode_q == SDCD_M_SUSPEND && !clock_gate_now) ##1 clock_gate_now [*4]
        |-> ##[0:1] mode_q == SDCD_M_NORMAL) else $error("no resume");
    a_pdown_entry: assert property (
        (bank_open_q == 0 && mode_q == SDCD_M_NORMAL) ##0 pd_drop
        |-> ##[0:1] mode_q == SDCD_M_PDOWN) else $error("no power down");
    a_sref_entry: assert property (
        (bank_open_q == 0 && mode_q == SDCD_M_NORMAL) ##0 sref_drop
        |-> ##[0:1] mode_q == SDCD_M_SREF) else $error("no self refresh");
endmodule

/* File: tb/tb_sdcd.sv */
// testbench: controller joined to device, decode and gate modes
`timescale 1ns/100ps
module tb_sdcd;
    import sdcd_pkg::*;
    logic                 clock;
    logic                 nrst;
    logic                 req_valid;
    logic [2:0]           req_pattern;
    logic [BANK_W-1:0]    req_bank;
    logic [ADDR_W-1:0]    req_addr;
    logic                 gate_req;
    logic [MASK_W-1:0]    req_mask;
    logic                 full_page;
    logic                 burst_busy;
    logic [BANK_W-1:0]    cmd_bank_q;
    logic [ADDR_W-1:0]    cmd_addr_q;
    logic [MASK_W-1:0]    write_en_q;
    logic                 out_drive_q;
    logic                 req_ready;
    sdcd_cmd_type         cmd_q;
    logic                 cmd_valid_q;
    logic                 illegal_q;
    logic [NUM_BANKS-1:0] bank_open_q;
    sdcd_mode_type        mode_q;
    int                   mismatches;
    int                   cmp_count;
    int                   cycles;

    sdcd_if sdcd_if_i ();
    sdcd_ctrl sdcd_ctrl_i (.clock(clock), .nrst(nrst), .req_valid(req_valid),
        .req_pattern(req_pattern), .req_bank(req_bank), .req_addr(req_addr),
        .req_mask(req_mask), .gate_req(gate_req), .req_ready(req_ready), .pins(sdcd_if_i));
    sdcd_device sdcd_device_i (.clock(clock), .nrst(nrst), .pins(sdcd_if_i),
        .cmd_q(cmd_q), .cmd_valid_q(cmd_valid_q), .cmd_bank_q(cmd_bank_q),
        .cmd_addr_q(cmd_addr_q), .illegal_q(illegal_q), .bank_open_q(bank_open_q),
        .burst_busy(burst_busy), .mode_q(mode_q), .write_en_q(write_en_q),
        .out_drive_q(out_drive_q), .full_page(full_page));
    sdcd_monitor sdcd_monitor_i (.clock(clock), .nrst(nrst),
        .clock_gate_now(sdcd_if_i.clock_gate_now), .cs_n(sdcd_if_i.cs_n),
        .ras_n(sdcd_if_i.ras_n), .cas_n(sdcd_if_i.cas_n), .we_n(sdcd_if_i.we_n),
        .addr(sdcd_if_i.addr), .cmd_q(cmd_q), .cmd_valid_q(cmd_valid_q),
        .bank_open_q(bank_open_q), .mode_q(mode_q));

    initial
    begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    task automatic test_done();
        $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk_val(input string nm, input logic [11:0] e, input logic [11:0] g);
        cmp_count++;
        if (g !== e)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_cmd(input sdcd_cmd_type e, input sdcd_cmd_type g);
        cmp_count++;
        if (g !== e)
        begin
            mismatches++;
            $display("CHECK FAILED cmd_q expected %s seen %s", e.name(), g.name());
        end
    endtask

    // exp of none means the command must be flagged illegal
    task automatic op(input logic [2:0] p, input logic [1:0] b, input logic [11:0] a,
                      input sdcd_cmd_type e);
        int n;
        @(negedge clock);
        req_valid = 1'b1;
        req_pattern = p;
        req_bank = b;
        req_addr = a;
        for (n = 0; req_ready !== 1'b1 && n < 20; n++)
            @(negedge clock);
        @(negedge clock);
        req_valid = 1'b0;
        req_pattern = PAT_NOP;
        for (n = 0; n < 10 && illegal_q !== 1'b1 && !(cmd_valid_q === 1'b1 &&
             !(cmd_q inside {SDCD_C_NOP, SDCD_C_DESEL})); n++)
            @(negedge clock);
        if (e == SDCD_C_NONE)
            chk_val("illegal_q", 12'h1, {11'h0, illegal_q});
        else
        begin
            chk_cmd(e, cmd_q);
            chk_val("illegal_q", 12'h0, {11'h0, illegal_q});
        end
    endtask

    task automatic gate(input logic v, input sdcd_mode_type m);
        int n;
        @(negedge clock);
        gate_req = v;
        for (n = 0; mode_q !== m && n < 10; n++)
            @(negedge clock);
        chk_val("mode_q", 12'(m), 12'(mode_q));
    endtask

    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            mismatches++;
            test_done();
        end
    end

    initial
    begin
        int n;
        nrst = 1'b0;
        req_valid = 1'b0;
        req_pattern = PAT_NOP;
        req_bank = 2'h0;
        req_addr = 12'h000;
        gate_req = 1'b1;
        req_mask = 2'h0;
        full_page = 1'b0;
        mismatches = 0;
        cmp_count = 0;
        cycles = 0;
        repeat (2) @(negedge clock);
        nrst = 1'b1;
        op(PAT_RD, 2'h1, 12'h000, SDCD_C_NONE);
        op(PAT_ACT, 2'h1, 12'h010, SDCD_C_ACT);
        chk_val("bank_open_q", 12'h002, 12'(bank_open_q));
        op(PAT_RD, 2'h1, 12'h000, SDCD_C_RD);
        op(PAT_WR, 2'h1, 12'h008, SDCD_C_WR);
        gate(1'b0, SDCD_M_SUSPEND);
        gate(1'b1, SDCD_M_NORMAL);
        op(PAT_ACT, 2'h3, 12'h020, SDCD_C_ACT);
        op(PAT_PRE, 2'h3, 12'h000, SDCD_C_PRE);
        chk_val("bank_open_q", 12'h002, 12'(bank_open_q));
        op(PAT_PRE, 2'h0, 12'h400, SDCD_C_PREALL);
        chk_val("bank_open_q", 12'h000, 12'(bank_open_q));
        op(PAT_ACT, 2'h1, 12'h030, SDCD_C_ACT);
        chk_val("cmd_bank_q", 12'h001, 12'(cmd_bank_q));
        chk_val("cmd_addr_q", 12'h030, cmd_addr_q);
        op(PAT_RD, 2'h1, 12'h400, SDCD_C_RDA);
        for (n = 0; bank_open_q !== 4'h0 && n < 40; n++)
            @(negedge clock);
        chk_val("bank_open_q", 12'h000, 12'(bank_open_q));
        op(PAT_MRS, 2'h0, 12'h022, SDCD_C_MRS);
        op(PAT_REF, 2'h0, 12'h000, SDCD_C_REF);
        gate(1'b0, SDCD_M_PDOWN);
        gate(1'b1, SDCD_M_NORMAL);
        @(negedge clock);
        gate_req = 1'b0;
        req_valid = 1'b1;
        req_pattern = PAT_REF;
        gate(1'b0, SDCD_M_SREF);
        req_valid = 1'b0;
        req_pattern = PAT_NOP;
        gate(1'b1, SDCD_M_NORMAL);
        op(PAT_ACT, 2'h2, 12'h040, SDCD_C_ACT);
        op(PAT_BST, 2'h2, 12'h000, SDCD_C_NONE);
        full_page = 1'b1;
        req_mask = 2'h1;
        op(PAT_RD, 2'h2, 12'h000, SDCD_C_RD);
        chk_val("write_en_q", 12'h002, 12'(write_en_q));
        chk_val("out_drive_q", 12'h001, 12'(out_drive_q));
        req_mask = 2'h0;
        repeat (20) @(negedge clock);
        chk_val("burst_busy", 12'h001, 12'(burst_busy));
        op(PAT_BST, 2'h2, 12'h000, SDCD_C_BST);
        chk_val("burst_busy", 12'h000, 12'(burst_busy));
        test_done();
    end
endmodule
